// [rtl/sssf_pkg.sv]
// Package for the spindle synchronisation status flag block.
// Assumes a 32-bit classic Wishbone register bus on a 125 MHz clock.
package sssf_pkg;

    // Bus and register geometry
    localparam int unsigned SSSF_DATA_W = 32;
    localparam int unsigned SSSF_ADDR_W = 8;
    localparam int unsigned SSSF_SPEED_W = 32;
    localparam int unsigned SSSF_PHASE_W = 16;

    // Register byte offsets
    localparam logic [SSSF_ADDR_W-1:0] SSSF_REG_STATUS = 8'h00;
    localparam logic [SSSF_ADDR_W-1:0] SSSF_REG_SPEED = 8'h04;
    localparam logic [SSSF_ADDR_W-1:0] SSSF_REG_PHASE_LEVEL = 8'h08;
    localparam logic [SSSF_ADDR_W-1:0] SSSF_REG_PARAM_EVENT = 8'h0c;
    localparam logic [SSSF_ADDR_W-1:0] SSSF_REG_PHASE_DIFF = 8'h10;

    // Status register bit positions
    localparam int unsigned SSSF_ST_PHASE_SYNC = 0;
    localparam int unsigned SSSF_ST_POLYGON = 1;
    localparam int unsigned SSSF_ST_CHUCK = 2;
    localparam int unsigned SSSF_ST_REBOOT = 3;
    localparam int unsigned SSSF_ST_BRG_READY = 4;
    localparam int unsigned SSSF_ST_BRG_SERVO = 5;
    localparam int unsigned SSSF_ST_BRG_WARN = 6;
    localparam int unsigned SSSF_ST_BRG_ALARM = 7;
    localparam int unsigned SSSF_ST_SYNC_ACTIVE = 8;
    localparam int unsigned SSSF_ST_PHASE_MODE = 9;

    // Parameter event register bit positions (write one to signal)
    localparam int unsigned SSSF_PE_REBOOT_PARAM = 0;
    localparam int unsigned SSSF_PE_AUX_REBOOT_PARAM = 1;
    localparam int unsigned SSSF_PE_IMMEDIATE_PARAM = 2;
    localparam int unsigned SSSF_PE_MAINT_LOAD = 3;
    localparam int unsigned SSSF_PE_BACKUP_RESTORE = 4;

    // Reset values
    localparam logic [SSSF_PHASE_W-1:0] SSSF_PHASE_LEVEL_RST = 16'h0010;
    localparam logic [SSSF_SPEED_W-1:0] SSSF_SPEED_RST = 32'h0000_0000;
    localparam logic [SSSF_DATA_W-1:0] SSSF_UNMAPPED_READ = 32'h0000_0000;

    // Synchroniser depth for pins arriving from outside the clock domain
    localparam int unsigned SSSF_SYNC_STAGES = 2;

endpackage

// [rtl/sssf_status_flags.sv]
// Spindle synchronisation status flags with a classic Wishbone slave.
// Assumes NC-side command pulses are on clk_i; PLC outputs and bearing
// amplifier levels are asynchronous and are synchronised here.
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/100ps
module sssf_status_flags #(
    parameter int unsigned SPEED_W = sssf_pkg::SSSF_SPEED_W,
    parameter int unsigned PHASE_W = sssf_pkg::SSSF_PHASE_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sssf_pkg::SSSF_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [sssf_pkg::SSSF_DATA_W-1:0] wb_dat_i,
    output logic [sssf_pkg::SSSF_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // NC command events, one-cycle pulses on clk_i
    input wire logic sync_start_i,
    input wire logic polygon_start_i,
    input wire logic sync_cancel_cmd_i,
    input wire logic phase_align_done_i,
    input wire logic speed_change_i,
    // Spindle phase positions, on clk_i
    input wire logic [PHASE_W-1:0] ref_phase_i,
    input wire logic [PHASE_W-1:0] fol_phase_i,
    // PLC outputs, asynchronous levels
    input wire logic spindle_sync_request_i,
    input wire logic phase_sync_request_i,
    input wire logic sync_cancel_input_i,
    input wire logic chuck_close_request_i,
    // Magnetic bearing amplifier, asynchronous levels
    input wire logic brg_ready_i,
    input wire logic brg_servo_on_i,
    input wire logic brg_warning_i,
    input wire logic brg_alarm_i,
    // S command path, on clk_i
    input wire logic s_cmd_valid_i,
    input wire logic [SPEED_W-1:0] s_cmd_data_i,
    input wire logic s_finish_i,
    input wire logic css_active_i,
    input wire logic [SPEED_W-1:0] css_speed_i,
    input wire logic nc_reset_i,
    input wire logic emergency_stop_i,
    // Status flags towards the PLC
    output logic spindle_sync_active_o,
    output logic phase_sync_complete_o,
    output logic polygon_machining_active_o,
    output logic chuck_close_confirmation_o,
    output logic reboot_pending_o,
    output logic reboot_pending_indicator_o,
    output logic brg_ready_o,
    output logic brg_servo_on_o,
    output logic brg_warning_o,
    output logic brg_alarm_o,
    output logic [SPEED_W-1:0] speed_cmd_o
);
    import sssf_pkg::*;

    // Wrap-around distance between two phase positions
    function automatic logic [PHASE_W-1:0] phase_dist(
        input logic [PHASE_W-1:0] a,
        input logic [PHASE_W-1:0] b
    );
        logic [PHASE_W-1:0] d;
        logic [PHASE_W-1:0] e;
        d = a - b;
        e = b - a;
        phase_dist = (d < e) ? d : e;
    endfunction

    // Zero-extend a narrow field to a bus word
    function automatic logic [SSSF_DATA_W-1:0] to_word(
        input logic [PHASE_W-1:0] v
    );
        to_word = {{(SSSF_DATA_W-PHASE_W){1'b0}}, v};
    endfunction

    // Asynchronous level inputs, two-stage synchronisers
    localparam int unsigned NUM_ASYNC = 8;
    logic [NUM_ASYNC-1:0] async_raw;
    logic [NUM_ASYNC-1:0] sync_s1;
    logic [NUM_ASYNC-1:0] sync_s2;
    logic sync_req;
    logic phase_req;
    logic cancel_in;
    logic chuck_req;
    logic cancel_in_d;

    assign async_raw = {brg_alarm_i, brg_warning_i, brg_servo_on_i,
                        brg_ready_i, chuck_close_request_i,
                        sync_cancel_input_i, phase_sync_request_i,
                        spindle_sync_request_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_s1 <= '0;
            sync_s2 <= '0;
        end else begin
            sync_s1 <= async_raw;
            sync_s2 <= sync_s1;
        end
    end

    assign sync_req = sync_s2[0];
    assign phase_req = sync_s2[1];
    assign cancel_in = sync_s2[2];
    assign chuck_req = sync_s2[3];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cancel_in_d <= 1'b0;
        end else begin
            cancel_in_d <= cancel_in;
        end
    end

    // Cancel events: command code or rising edge of the external input
    logic cancel_evt;
    logic sync_req_d;
    logic sync_req_fall;
    assign cancel_evt = sync_cancel_cmd_i | (cancel_in & ~cancel_in_d);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_req_d <= 1'b0;
        end else begin
            sync_req_d <= sync_req;
        end
    end
    assign sync_req_fall = sync_req_d & ~sync_req;

    // Spindle synchronous control: by command or by the PLC request level
    logic cmd_sync;
    logic sync_active;
    logic sync_cancelled;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_sync <= 1'b0;
        end else if (cancel_evt) begin
            cmd_sync <= 1'b0;
        end else if (sync_start_i) begin
            cmd_sync <= 1'b1;
        end
    end

    assign sync_active = cmd_sync | sync_req;
    assign sync_cancelled = (cmd_sync & cancel_evt & ~sync_req)
                            | (sync_req_fall & ~cmd_sync);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spindle_sync_active_o <= 1'b0;
        end else begin
            spindle_sync_active_o <= sync_active;
        end
    end

    // Phase synchronisation mode and threshold check
    logic phase_mode;
    logic [PHASE_W-1:0] phase_level;
    logic [PHASE_W-1:0] phase_diff;
    logic phase_over;

    assign phase_mode = sync_active & phase_req;
    assign phase_diff = phase_dist(ref_phase_i, fol_phase_i);
    assign phase_over = phase_diff > phase_level;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_sync_complete_o <= 1'b0;
        end else if (sync_cancelled || !sync_active) begin
            phase_sync_complete_o <= 1'b0;
        end else if (!phase_mode || speed_change_i) begin
            // Dropped while the mode is off or the speed is being changed
            phase_sync_complete_o <= 1'b0;
        end else if (phase_align_done_i) begin
            phase_sync_complete_o <= 1'b1;
        end else if (phase_over) begin
            phase_sync_complete_o <= 1'b0;
        end
    end

    // Spindle-spindle polygon machining
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            polygon_machining_active_o <= 1'b0;
        end else if (sync_cancel_cmd_i) begin
            polygon_machining_active_o <= 1'b0;
        end else if (cancel_in & ~cancel_in_d) begin
            polygon_machining_active_o <= 1'b0;
        end else if (polygon_start_i) begin
            polygon_machining_active_o <= 1'b1;
        end
    end

    // Chuck close confirmation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chuck_close_confirmation_o <= 1'b0;
        end else if (!sync_active || sync_cancelled) begin
            chuck_close_confirmation_o <= 1'b0;
        end else begin
            chuck_close_confirmation_o <= chuck_req;
        end
    end

    // Magnetic bearing status, straight from the synchronised levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brg_ready_o <= 1'b0;
            brg_servo_on_o <= 1'b0;
            brg_warning_o <= 1'b0;
            brg_alarm_o <= 1'b0;
        end else begin
            brg_ready_o <= sync_s2[4];
            brg_servo_on_o <= sync_s2[5];
            brg_warning_o <= sync_s2[6];
            brg_alarm_o <= sync_s2[7];
        end
    end

    // Wishbone decode
    logic bus_req;
    logic bus_wr;
    logic lane0;
    logic lane1;
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;
    assign lane0 = wb_sel_i[0];
    assign lane1 = wb_sel_i[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Phase attainment level, written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_level <= SSSF_PHASE_LEVEL_RST;
        end else if (bus_wr && wb_adr_i == SSSF_REG_PHASE_LEVEL) begin
            if (lane0) begin
                phase_level[7:0] <= wb_dat_i[7:0];
            end
            if (lane1) begin
                phase_level[PHASE_W-1:8] <= wb_dat_i[PHASE_W-1:8];
            end
        end
    end

    // Parameter events through the bus
    logic pe_hit;
    logic reboot_evt;
    assign pe_hit = bus_wr && lane0 && wb_adr_i == SSSF_REG_PARAM_EVENT;
    // Immediate-effect writes are deliberately not part of this term
    assign reboot_evt = pe_hit
        && (wb_dat_i[SSSF_PE_REBOOT_PARAM]
            || wb_dat_i[SSSF_PE_AUX_REBOOT_PARAM]
            || wb_dat_i[SSSF_PE_MAINT_LOAD]
            || wb_dat_i[SSSF_PE_BACKUP_RESTORE]);

    // Only the power-on reset clears it; value restores never do
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reboot_pending_o <= 1'b0;
        end else if (reboot_evt) begin
            reboot_pending_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reboot_pending_indicator_o <= 1'b0;
        end else begin
            reboot_pending_indicator_o <= reboot_evt | reboot_pending_o;
        end
    end

    // Commanded speed: S value held until the finish answer or css_active_i renews it
    logic [SPEED_W-1:0] s_pending;
    logic s_pending_valid;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_pending <= SSSF_SPEED_RST;
            s_pending_valid <= 1'b0;
        end else if (s_cmd_valid_i) begin
            s_pending <= s_cmd_data_i;
            s_pending_valid <= 1'b1;
        end else if (s_finish_i) begin
            s_pending_valid <= 1'b0;
        end
    end

    // NC reset and emergency stop are deliberately not terms here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            speed_cmd_o <= SSSF_SPEED_RST;
        end else if (css_active_i) begin
            speed_cmd_o <= css_speed_i;
        end else if (s_finish_i && s_pending_valid) begin
            speed_cmd_o <= s_pending;
        end
    end

    // Read mux
    logic [SSSF_DATA_W-1:0] status_word;
    logic [SSSF_DATA_W-1:0] next_rdata;

    always_comb begin
        status_word = '0;
        status_word[SSSF_ST_PHASE_SYNC] = phase_sync_complete_o;
        status_word[SSSF_ST_POLYGON] = polygon_machining_active_o;
        status_word[SSSF_ST_CHUCK] = chuck_close_confirmation_o;
        status_word[SSSF_ST_REBOOT] = reboot_pending_o;
        status_word[SSSF_ST_BRG_READY] = brg_ready_o;
        status_word[SSSF_ST_BRG_SERVO] = brg_servo_on_o;
        status_word[SSSF_ST_BRG_WARN] = brg_warning_o;
        status_word[SSSF_ST_BRG_ALARM] = brg_alarm_o;
        status_word[SSSF_ST_SYNC_ACTIVE] = spindle_sync_active_o;
        status_word[SSSF_ST_PHASE_MODE] = phase_mode;
    end

    always_comb begin
        case (wb_adr_i)
            SSSF_REG_STATUS: next_rdata = status_word;
            SSSF_REG_SPEED: next_rdata = speed_cmd_o;
            SSSF_REG_PHASE_LEVEL: next_rdata = to_word(phase_level);
            SSSF_REG_PHASE_DIFF: next_rdata = to_word(phase_diff);
            default: next_rdata = SSSF_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    // Unused inputs kept for the NC interface; they change no state
    logic unused_ok;
    assign unused_ok = nc_reset_i ^ emergency_stop_i ^ (^wb_sel_i[3:2]);

endmodule

// [sim/sssf_status_flags_checker.sv]
// Concurrent checks on the status flag block, ports only.
// Assumes one clock, synchronous active-high reset; bound from the bench.
`timescale 1ns/100ps
module sssf_status_flags_checker #(
    parameter int unsigned SPEED_W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic polygon_start_i,
    input wire logic sync_cancel_cmd_i,
    input wire logic sync_cancel_input_i,
    input wire logic brg_ready_i,
    input wire logic brg_servo_on_i,
    input wire logic brg_warning_i,
    input wire logic brg_alarm_i,
    input wire logic s_finish_i,
    input wire logic css_active_i,
    input wire logic nc_reset_i,
    input wire logic emergency_stop_i,
    input wire logic spindle_sync_active_o,
    input wire logic phase_sync_complete_o,
    input wire logic polygon_machining_active_o,
    input wire logic chuck_close_confirmation_o,
    input wire logic reboot_pending_o,
    input wire logic reboot_pending_indicator_o,
    input wire logic brg_ready_o,
    input wire logic brg_servo_on_o,
    input wire logic brg_warning_o,
    input wire logic brg_alarm_o,
    input wire logic [SPEED_W-1:0] speed_cmd_o
);
    logic [2:0] up;
    logic [9:0] flags;
    assign flags = {spindle_sync_active_o, phase_sync_complete_o,
        polygon_machining_active_o, chuck_close_confirmation_o,
        reboot_pending_o, reboot_pending_indicator_o, brg_ready_o,
        brg_servo_on_o, brg_warning_o, brg_alarm_o};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since reset release, so pipelines have refilled
    always_ff @(posedge clk_i) begin
        if (rst_i)
            up <= 3'h0;
        else if (up != 3'h7)
            up <= up + 3'h1;
    end
    AST_POLY_SET: assert property (
        polygon_start_i && !sync_cancel_cmd_i |=> polygon_machining_active_o)
        else $error("polygon flag did not set");
    AST_POLY_CLR: assert property (
        sync_cancel_cmd_i |=> !polygon_machining_active_o)
        else $error("polygon flag kept after cancel command");
    AST_POLY_EXT: assert property (
        up == 3'h7 && $rose(sync_cancel_input_i) && !polygon_start_i
        |-> ##[3:5] !polygon_machining_active_o)
        else $error("polygon flag kept after cancel input");
    AST_SYNC_OFF: assert property (
        !spindle_sync_active_o [*2]
        |-> !chuck_close_confirmation_o && !phase_sync_complete_o)
        else $error("flag set outside synchronous control");
    AST_REBOOT_HOLD: assert property (
        reboot_pending_o |=> reboot_pending_o)
        else $error("reboot pending cleared without reset");
    AST_INDICATOR: assert property (
        reboot_pending_indicator_o == reboot_pending_o)
        else $error("indicator differs from reboot pending");
    AST_BRG: assert property (
        ($stable({brg_ready_i, brg_servo_on_i, brg_warning_i, brg_alarm_i})
        && up == 3'h7) [*3] |-> {brg_ready_o, brg_servo_on_o, brg_warning_o,
        brg_alarm_o} == {brg_ready_i, brg_servo_on_i, brg_warning_i,
        brg_alarm_i})
        else $error("bearing flags do not follow inputs");
    AST_SPEED_KEEP: assert property (
        (nc_reset_i || emergency_stop_i) && !s_finish_i && !css_active_i
        |=> $stable(speed_cmd_o))
        else $error("speed word changed on reset or stop");
    AST_RST_CLEAR: assert property (disable iff (1'b0)
        rst_i |=> flags == 10'h000)
        else $error("flag set after reset");
    cover property (polygon_start_i ##1 polygon_machining_active_o);
    cover property ($rose(chuck_close_confirmation_o));
    cover property ($rose(reboot_pending_o));
endmodule

// [sim/sssf_plc_model.sv]
// Sequence program model: drives the PLC level outputs of the block.
// Assumes the bench calls its tasks; changes land just after a clock edge.
`timescale 1ns/100ps
module sssf_plc_model (
    input wire logic clk_i,
    input wire logic brg_servo_on_o,
    input wire logic phase_sync_complete_o,
    output logic spindle_sync_request_i,
    output logic phase_sync_request_i,
    output logic sync_cancel_input_i,
    output logic chuck_close_request_i
);
    initial begin
        {chuck_close_request_i, sync_cancel_input_i} = 2'h0;
        {phase_sync_request_i, spindle_sync_request_i} = 2'h0;
    end
    task automatic set(input logic [3:0] v);
        @(posedge clk_i);
        {chuck_close_request_i, sync_cancel_input_i,
            phase_sync_request_i, spindle_sync_request_i} <= v;
    endtask
    // Clamp only once phases are aligned
    task automatic clamp(output logic ok);
        int n;
        n = 0;
        while (phase_sync_complete_o !== 1'b1 && n < 64) begin
            @(posedge clk_i);
            n++;
        end
        ok = (n < 64);
        @(posedge clk_i);
        chuck_close_request_i <= ok;
    endtask
    // Spindle run is only allowed with the shaft suspended
    task automatic run(output logic ok);
        ok = (brg_servo_on_o === 1'b1);
    endtask
endmodule

// [sim/sssf_status_flags_test.sv]
// Self-checking bench for the spindle status flag block.
// Assumes the design package and the PLC model are compiled first.
`timescale 1ns/100ps
module sssf_status_flags_test;
    import sssf_pkg::*;
    localparam int unsigned SPEED_W = SSSF_SPEED_W;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [SSSF_ADDR_W-1:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf, wsel = 4'hf;
    logic [SSSF_DATA_W-1:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [8:0] ev = 9'h000;
    wire logic sync_start_i, polygon_start_i, sync_cancel_cmd_i;
    wire logic phase_align_done_i, speed_change_i, s_cmd_valid_i;
    wire logic s_finish_i, nc_reset_i, emergency_stop_i;
    logic [SSSF_PHASE_W-1:0] ref_phase_i = 16'h1000, fol_phase_i = 16'h1000;
    logic brg_ready_i = 0, brg_servo_on_i = 0, brg_warning_i = 0;
    logic brg_alarm_i = 0, css_active_i = 0, ok;
    logic [SPEED_W-1:0] s_cmd_data_i = 32'h0, css_speed_i = 32'h0, speed_cmd_o;
    logic spindle_sync_request_i, phase_sync_request_i;
    logic sync_cancel_input_i, chuck_close_request_i, wb_ack_o;
    logic spindle_sync_active_o, phase_sync_complete_o, reboot_pending_o;
    logic polygon_machining_active_o, chuck_close_confirmation_o;
    logic reboot_pending_indicator_o, brg_ready_o, brg_servo_on_o;
    logic brg_warning_o, brg_alarm_o;
    int bad_count = 0, total_checks = 0, cyc = 0;
    assign {emergency_stop_i, nc_reset_i, s_finish_i, s_cmd_valid_i,
        speed_change_i, phase_align_done_i, sync_cancel_cmd_i,
        polygon_start_i, sync_start_i} = ev;
    sssf_status_flags DUT (.*);
    sssf_plc_model plc (.*);
    initial forever #4 clk_i = ~clk_i;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim;
        end
    end
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_word({31'h0, g}, {31'h0, e});
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        wb_sel_i <= wsel;
        // Only the bench timeout ends a wait for the answer
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic fire(input int k);
        @(posedge clk_i);
        ev <= 9'h001 << k;
        @(posedge clk_i);
        ev <= 9'h000;
        @(negedge clk_i);
    endtask
    task automatic por;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic w6;
        repeat (6) @(negedge clk_i);
    endtask
    initial begin
        por;
        chk_word(DUT.spindle_sync_active_o, 1'b0);
        chk_word({reboot_pending_o, phase_sync_complete_o, brg_alarm_o}, 0);
        wb(0, SSSF_REG_PHASE_LEVEL, 0);
        chk_word(rd, {16'h0, SSSF_PHASE_LEVEL_RST});
        wb(1, 8'h20, 32'hffff);
        wb(0, 8'h20, 0);
        chk_word(rd, SSSF_UNMAPPED_READ);
        fire(0);
        @(negedge clk_i);
        chk_bit(spindle_sync_active_o, 1);
        fire(1);
        chk_bit(polygon_machining_active_o, 1);
        fire(2);
        chk_bit(polygon_machining_active_o, 0);
        @(negedge clk_i);
        chk_bit(spindle_sync_active_o, 0);
        fire(1);
        plc.set(4'b0100);
        w6;
        chk_bit(polygon_machining_active_o, 0);
        plc.set(4'b1001);
        w6;
        chk_bit(chuck_close_confirmation_o, 1);
        plc.set(4'b0001);
        w6;
        chk_bit(chuck_close_confirmation_o, 0);
        plc.set(4'b1000);
        w6;
        chk_bit(chuck_close_confirmation_o, 0);
        plc.set(4'b0011);
        w6;
        fire(3);
        chk_bit(phase_sync_complete_o, 1);
        @(posedge clk_i);
        fol_phase_i <= 16'h1010;
        w6;
        chk_bit(phase_sync_complete_o, 1);
        @(posedge clk_i);
        ref_phase_i <= 16'h0fff;
        w6;
        chk_bit(phase_sync_complete_o, 0);
        wb(1, SSSF_REG_PHASE_LEVEL, 32'h20);
        fire(3);
        w6;
        chk_bit(phase_sync_complete_o, 1);
        fire(4);
        chk_bit(phase_sync_complete_o, 0);
        fire(3);
        plc.clamp(ok);
        chk_bit(ok, 1);
        w6;
        chk_bit(chuck_close_confirmation_o, ok);
        plc.set(4'b0000);
        w6;
        chk_bit(phase_sync_complete_o, 0);
        wb(1, SSSF_REG_PARAM_EVENT, 32'h4);
        chk_bit(reboot_pending_o, 0);
        for (int i = 0; i < 5; i++) begin
            if (i != SSSF_PE_IMMEDIATE_PARAM) begin
                por;
                chk_bit(reboot_pending_o, 0);
                wb(1, SSSF_REG_PARAM_EVENT, 32'h1 << i);
                @(negedge clk_i);
                chk_bit(reboot_pending_o, 1);
                chk_bit(reboot_pending_indicator_o, 1);
                wb(1, SSSF_REG_PARAM_EVENT, 32'h1 << i);
                wb(1, SSSF_REG_PARAM_EVENT, 32'h4);
                wb(0, SSSF_REG_STATUS, 0);
                chk_bit(rd[SSSF_ST_REBOOT], 1);
            end
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            {brg_alarm_i, brg_warning_i, brg_servo_on_i, brg_ready_i} <= 4'h1 << i;
            w6;
            chk_word({brg_alarm_o, brg_warning_o, brg_servo_on_o, brg_ready_o},
                1 << i);
            plc.run(ok);
            chk_bit(ok, i == 1);
        end
        @(posedge clk_i);
        s_cmd_data_i <= 32'h1f4;
        fire(5);
        fire(6);
        chk_word(speed_cmd_o, 32'h1f4);
        fire(7);
        fire(8);
        wb(0, SSSF_REG_SPEED, 0);
        chk_word(rd, 32'h1f4);
        css_speed_i <= 32'h258;
        css_active_i <= 1'b1;
        @(posedge clk_i);
        css_active_i <= 1'b0;
        @(negedge clk_i);
        chk_word(speed_cmd_o, 32'h258);
        // Lane 0 only: the upper byte of the level keeps its reset value
        wsel = 4'h1;
        wb(1, SSSF_REG_PHASE_LEVEL, 32'h0000_abcd);
        wsel = 4'hf;
        wb(0, SSSF_REG_PHASE_LEVEL, 0);
        chk_word(rd, 32'h0000_00cd);
        end_sim;
    end
endmodule
bind sssf_status_flags sssf_status_flags_checker #(.SPEED_W(SPEED_W)) u_chk (
    .clk_i, .rst_i, .polygon_start_i, .sync_cancel_cmd_i,
    .sync_cancel_input_i, .brg_ready_i, .brg_servo_on_i, .brg_warning_i,
    .brg_alarm_i, .s_finish_i, .css_active_i, .nc_reset_i, .emergency_stop_i,
    .spindle_sync_active_o, .phase_sync_complete_o,
    .polygon_machining_active_o, .chuck_close_confirmation_o,
    .reboot_pending_o, .reboot_pending_indicator_o, .brg_ready_o,
    .brg_servo_on_o, .brg_warning_o, .brg_alarm_o, .speed_cmd_o);
